// File: bus_cycle_sequencer.sv
/*
 Bus cycle sequencer: issues the machine cycles and strobes of one instruction.
 Assumes the core presents instr_class with start for one clock when idle, and
 supplies the address values; a new start is taken only when busy is low.
*/
`timescale 1ns/1ps
`include "bus_cycle_sequencer_regs.svh"
module bus_cycle_sequencer
   import bus_cycle_pkg::*;
(
   input wire logic clock,
   input wire logic rst,
   input wire logic start,
   input wire instr_class_t instr_class,
   input wire logic [15:0] pc_addr,
   input wire logic [15:0] sp_addr,
   input wire logic [15:0] index_addr,
   input wire logic [7:0] operand,
   input wire logic [7:0] accum,
   input wire logic wake,
   input wire logic bus_req,
   output logic [15:0] addr_r,
   output logic read_n_r,
   output logic write_n_r,
   output logic memory_request_n,
   output logic io_request_n,
   output logic first_cycle_indicator_n,
   output logic halt_n_r,
   output logic status_out,
   output logic data_oe_r,
   output logic busy_r,
   output logic bus_grant_r,
   output logic int_sample_r
);
   instr_class_t cls_r;
   logic [3:0] mc_r;
   logic [1:0] t_r;
   logic halted_r;
   logic [3:0] last_mc;
   logic last_state;
   cycle_kind_t kind;
   logic [15:0] addr_nxt;

   always_comb begin
      case (cls_r)
         INS_XCHG_IDX: last_mc = `CYC_XCHG_IDX;
         INS_IM: last_mc = `CYC_IM;
         INS_IDX_REG: last_mc = `CYC_IDX_REG;
         INS_IDX_MEM: last_mc = `CYC_IDX_MEM;
         INS_PORT_IMM: last_mc = `CYC_PORT_IMM;
         INS_PORT_PAGE0: last_mc = `CYC_PORT_PAGE0;
         default: last_mc = 4'h1;
      endcase
   end

   // Cycle kind per class and machine cycle number.
   always_comb begin
      kind = CK_IDLE;
      addr_nxt = pc_addr;
      case (cls_r)
         INS_XCHG_IDX: begin
            case (mc_r)
               4'h1, 4'h2: kind = CK_FETCH;
               4'h3, 4'h4: kind = CK_MEM_RD;
               4'h6, 4'h7: kind = CK_MEM_WR;
               default: kind = CK_IDLE;
            endcase
            if (mc_r == 4'h4 || mc_r == 4'h6) addr_nxt = sp_addr + 16'h0001;
            else if (mc_r > 4'h2) addr_nxt = sp_addr;
         end
         INS_IM: kind = CK_FETCH;
         INS_IDX_REG: kind = (mc_r == `CYC_IDX_REG) ? CK_IDLE : CK_FETCH;
         INS_IDX_MEM: begin
            case (mc_r)
               4'h1, 4'h2: kind = CK_FETCH;
               4'h3: kind = CK_OPERAND;
               4'h6: kind = CK_MEM_RD;
               4'h8: kind = CK_MEM_WR;
               default: kind = CK_IDLE;
            endcase
            // The displacement byte is signed, so it is sign-extended before the add.
            if (mc_r == 4'h6 || mc_r == 4'h8) begin
               addr_nxt = index_addr + {{8{operand[7]}}, operand};
            end
         end
         INS_PORT_IMM: begin
            case (mc_r)
               4'h1: kind = CK_FETCH;
               4'h2: kind = CK_OPERAND;
               default: kind = CK_IO_RD;
            endcase
            if (mc_r == `CYC_PORT_IMM) addr_nxt = {accum, operand};
         end
         INS_PORT_PAGE0: begin
            case (mc_r)
               4'h1, 4'h2: kind = CK_FETCH;
               4'h3: kind = CK_OPERAND;
               default: kind = CK_IO_RD;
            endcase
            if (mc_r == `CYC_PORT_PAGE0) addr_nxt = {`PAGE_ZERO_HIGH, operand};
         end
         default: kind = CK_FETCH;
      endcase
   end

   assign last_state = busy_r && t_r == `STATES_PER_ACCESS && mc_r == last_mc;

   always_ff @(posedge clock) begin
      if (rst) begin
         busy_r <= 1'b0;
         cls_r <= INS_HALT;
         mc_r <= 4'h1;
         t_r <= 2'h1;
      end else if (!busy_r) begin
         if (start) begin
            busy_r <= 1'b1;
            cls_r <= instr_class;
            mc_r <= 4'h1;
            t_r <= 2'h1;
         end
      end else if (t_r == `STATES_PER_ACCESS) begin
         t_r <= 2'h1;
         if (mc_r == last_mc && !(cls_r == INS_HALT && !wake)) begin
            busy_r <= 1'b0;
         end else if (mc_r != last_mc) begin
            mc_r <= mc_r + 4'h1;
         end
      end else begin
         t_r <= t_r + 2'h1;
      end
   end

   always_ff @(posedge clock) begin
      if (rst) halted_r <= 1'b0;
      else if (!busy_r) halted_r <= 1'b0;
      else if (cls_r == INS_HALT && t_r == `STATES_PER_ACCESS) halted_r <= !wake;
   end

   always_ff @(posedge clock) begin
      if (rst || !busy_r) begin
         read_n_r <= 1'b1;
         write_n_r <= 1'b1;
         memory_request_n <= 1'b1;
         io_request_n <= 1'b1;
         first_cycle_indicator_n <= 1'b1;
         status_out <= 1'b1;
         data_oe_r <= 1'b0;
         addr_r <= 16'h0000;
         halt_n_r <= 1'b1;
      end else begin
         addr_r <= addr_nxt;
         read_n_r <= !(kind == CK_FETCH || kind == CK_OPERAND || kind == CK_MEM_RD
                       || kind == CK_IO_RD);
         write_n_r <= kind != CK_MEM_WR;
         memory_request_n <= kind == CK_IO_RD || kind == CK_IDLE;
         io_request_n <= kind != CK_IO_RD;
         first_cycle_indicator_n <= kind != CK_FETCH;
         status_out <= !(kind == CK_FETCH && (mc_r == 4'h1 || halted_r));
         data_oe_r <= kind == CK_MEM_WR;
         halt_n_r <= !halted_r;
      end
   end

   always_ff @(posedge clock) begin
      if (rst) bus_grant_r <= 1'b0;
      else bus_grant_r <= bus_req && !busy_r && !start;
   end

   always_ff @(posedge clock) begin
      if (rst) int_sample_r <= 1'b0;
      else int_sample_r <= last_state && cls_r != INS_IM && cls_r != INS_HALT;
   end

   property p_grant_idle;
      @(posedge clock) disable iff (rst) busy_r |=> !bus_grant_r;
   endproperty
   a_grant_idle: assert property (p_grant_idle) else $error("grant during sequence");

   property p_no_int_im;
      @(posedge clock) disable iff (rst) (last_state && cls_r == INS_IM) |=> !int_sample_r;
   endproperty
   a_no_int_im: assert property (p_no_int_im) else $error("interrupt sampled");

   property p_port_imm;
      @(posedge clock) disable iff (rst)
         (busy_r && cls_r == INS_PORT_IMM && mc_r == 4'h3) |=>
         (!io_request_n && memory_request_n && addr_r == {accum, operand});
   endproperty
   a_port_imm: assert property (p_port_imm) else $error("bad port read");

   property p_page0;
      @(posedge clock) disable iff (rst)
         (busy_r && cls_r == INS_PORT_PAGE0 && mc_r == 4'h4) |=> addr_r[15:8] == 8'h00;
   endproperty
   a_page0: assert property (p_page0) else $error("page high not zero");

   sequence s_idx_write;
      busy_r && cls_r == INS_IDX_MEM && mc_r == 4'h8;
   endsequence
   property p_idx_mem;
      @(posedge clock) disable iff (rst) s_idx_write |=> !write_n_r && read_n_r;
   endproperty
   a_idx_mem: assert property (p_idx_mem) else $error("indexed write wrong");

   property p_idx_idle;
      @(posedge clock) disable iff (rst)
         (busy_r && cls_r == INS_IDX_REG && mc_r == 4'h3) |=>
         (read_n_r && write_n_r && memory_request_n && io_request_n && !data_oe_r);
   endproperty
   a_idx_idle: assert property (p_idx_idle) else $error("idle not idle");

   property p_halt;
      @(posedge clock) disable iff (rst)
         halted_r && busy_r |=> (!halt_n_r && !first_cycle_indicator_n);
   endproperty
   a_halt: assert property (p_halt) else $error("halt status wrong");

   property p_fetch;
      @(posedge clock) disable iff (rst)
         (busy_r && kind == CK_FETCH) |=> (!read_n_r && !memory_request_n && write_n_r);
   endproperty
   a_fetch: assert property (p_fetch) else $error("fetch strobes wrong");
endmodule

// File: bus_cycle_sequencer_regs.svh
/*
 Constants for the bus cycle sequencer: states per access, cycle counts, page-zero high byte.
 Assumes it is included by the sequencer module only.
*/
`ifndef BUS_CYCLE_SEQUENCER_REGS_SVH
`define BUS_CYCLE_SEQUENCER_REGS_SVH
`define STATES_PER_ACCESS 2'h3
`define CYC_PORT_IMM 4'h3
`define CYC_PORT_PAGE0 4'h4
`define CYC_IDX_MEM 4'h8
`define CYC_IDX_REG 4'h3
`define CYC_XCHG_IDX 4'h7
`define CYC_IM 4'h2
`define PAGE_ZERO_HIGH 8'h00
`endif

// File: bus_cycle_pkg.sv
/*
 Types for the bus cycle sequencer: instruction class and cycle kind.
 Assumes the sequencer and its bench are the only users.
*/
package bus_cycle_pkg;
   typedef enum logic [2:0] {
      INS_XCHG_IDX = 3'b000,
      INS_HALT = 3'b001,
      INS_IM = 3'b010,
      INS_IDX_REG = 3'b011,
      INS_IDX_MEM = 3'b100,
      INS_PORT_IMM = 3'b101,
      INS_PORT_PAGE0 = 3'b110
   } instr_class_t;
   typedef enum logic [2:0] {
      CK_FETCH = 3'b000,
      CK_OPERAND = 3'b001,
      CK_MEM_RD = 3'b010,
      CK_MEM_WR = 3'b011,
      CK_IO_RD = 3'b100,
      CK_IDLE = 3'b101
   } cycle_kind_t;
endpackage

// File: bus_devices_model.sv
/*
 Model of the memory and I/O devices: logs one bus snapshot per machine cycle.
 Assumes registered strobes that hold for three clocks in every machine cycle.
*/
`timescale 1ns/1ps
module bus_devices_model (
   input wire logic clock,
   input wire logic rst,
   input wire logic busy_r,
   input wire logic [15:0] addr_r,
   input wire logic [7:0] strobes
);
   logic [23:0] seen[$];
   logic active = 1'b0;
   logic [1:0] phase = 2'h0;
   // Sampling in the middle state keeps clear of the edges where strobes change.
   always @(negedge clock) begin
      if (rst) begin
         active = 1'b0;
      end else if (!active) begin
         active = !strobes[5];
         phase = 2'h1;
      end else if (!busy_r && strobes[7:1] == 7'h7f) begin
         active = 1'b0;
      end else begin
         if (phase == 2'h1) begin
            seen.push_back({addr_r, strobes});
         end
         phase = (phase == 2'h2) ? 2'h0 : phase + 2'h1;
      end
   end
endmodule

// File: bus_cycle_sequencer_tb.sv
/*
 Self-checking bench for the bus cycle sequencer.
 Assumes the device model logs strobes as rd, wr, memory_request_n, io_request_n, m1, halt, st, oe.
*/
`timescale 1ns/1ps
module bus_cycle_sequencer_tb;
   import bus_cycle_pkg::*;
   logic clock = 1'b0, rst = 1'b1, start = 1'b0, wake = 1'b0, bus_req = 1'b0;
   instr_class_t instr_class = INS_IM;
   logic [15:0] pc_addr = 16'h0100, sp_addr = 16'h8000, index_addr = 16'h4000;
   logic [7:0] operand = 8'h12, accum = 8'ha5;
   logic [15:0] addr_r;
   logic read_n_r, write_n_r, memory_request_n, io_request_n, first_cycle_indicator_n;
   logic halt_n_r, status_out, data_oe_r, busy_r, bus_grant_r, int_sample_r;
   int n_errors = 0, checked = 0, n_int = 0, n_gb = 0;
   always #2.5 clock = ~clock;
   bus_cycle_sequencer dut (.*);
   bus_devices_model bus (.clock(clock), .rst(rst), .busy_r(busy_r), .addr_r(addr_r),
      .strobes({read_n_r, write_n_r, memory_request_n, io_request_n,
      first_cycle_indicator_n, halt_n_r, status_out, data_oe_r}));
   // The interrupt sample count restarts with every instruction launch.
   always @(negedge clock) begin
      if (start) n_int = 0;
      else n_int += (int_sample_r === 1'b1);
      n_gb += (busy_r === 1'b1 && bus_grant_r === 1'b1);
   end
   task automatic check_bits(input string what, input logic [7:0] exp, input logic [7:0] got);
      checked++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic check_addr(input string what, input logic [15:0] exp, input logic [15:0] got);
      checked++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic summarize;
      $display("Checks %0d, errors %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask
   task automatic wait_busy(input logic level);
      for (int i = 0; i < 200 && busy_r !== level; i++) tick(1);
      if (busy_r !== level) begin
         check_bits("busy_r", {7'h0, level}, {7'h0, busy_r});
         summarize();
      end
   endtask
   task automatic launch(input instr_class_t c);
      bus.seen.delete();
      instr_class = c;
      start = 1'b1;
      tick(1);
      start = 1'b0;
      wait_busy(1'b1);
   endtask
   // Kinds are packed three bits each, first machine cycle in the top field.
   task automatic run(input instr_class_t c, input int n, input logic [23:0] kinds);
      logic [2:0] k;
      logic [7:0] e;
      launch(c);
      // A request while busy must wait until the sequence has ended.
      bus_req = (c == INS_IDX_MEM);
      wait_busy(1'b0);
      tick(4);
      check_bits("cycle count", n[7:0], 8'(bus.seen.size()));
      for (int i = 0; i < n; i++) begin
         k = kinds[3 * (n - 1 - i) +: 3];
         case (k)
            CK_FETCH: e = (i == 0) ? 8'h54 : 8'h56;
            CK_MEM_WR: e = 8'h9f;
            CK_IO_RD: e = 8'h6e;
            CK_IDLE: e = 8'hfe;
            default: e = 8'h5e;
         endcase
         check_bits("strobes", e, bus.seen[i][7:0]);
      end
   endtask
   initial begin
      tick(10);
      rst = 1'b0;
      run(INS_PORT_IMM, 3, {CK_FETCH, CK_OPERAND, CK_IO_RD});
      check_addr("io address", {accum, operand}, bus.seen[2][23:8]);
      check_bits("int samples", 8'h01, n_int[7:0]);
      run(INS_PORT_PAGE0, 4, {CK_FETCH, CK_FETCH, CK_OPERAND, CK_IO_RD});
      check_addr("page zero address", {8'h00, operand}, bus.seen[3][23:8]);
      run(INS_IDX_MEM, 8, {CK_FETCH, CK_FETCH, CK_OPERAND, CK_IDLE, CK_IDLE, CK_MEM_RD,
         CK_IDLE, CK_MEM_WR});
      check_addr("read address", index_addr + 16'h0012, bus.seen[5][23:8]);
      check_addr("write address", index_addr + 16'h0012, bus.seen[7][23:8]);
      check_bits("grant while busy", 8'h00, n_gb[7:0]);
      for (int i = 0; i < 20 && bus_grant_r !== 1'b1; i++) tick(1);
      check_bits("grant when idle", 8'h01, {7'h0, bus_grant_r});
      bus_req = 1'b0;
      tick(6);
      run(INS_IDX_REG, 3, {CK_FETCH, CK_FETCH, CK_IDLE});
      run(INS_IM, 2, {CK_FETCH, CK_FETCH});
      check_bits("int samples", 8'h00, n_int[7:0]);
      run(INS_XCHG_IDX, 7, {CK_FETCH, CK_FETCH, CK_MEM_RD, CK_MEM_RD, CK_IDLE, CK_MEM_WR,
         CK_MEM_WR});
      check_bits("int samples", 8'h01, n_int[7:0]);
      launch(INS_HALT);
      for (int i = 0; i < 60 && bus.seen.size() < 4; i++) tick(1);
      check_bits("halt cycles", 8'h04, 8'(bus.seen.size()));
      check_bits("first fetch", 8'h54, bus.seen[0][7:0]);
      check_addr("halt fetch address", pc_addr, bus.seen[1][23:8]);
      for (int i = 1; i < 4; i++) check_bits("halt fetch", 8'h50, bus.seen[i][7:0]);
      wake = 1'b1;
      wait_busy(1'b0);
      wake = 1'b0;
      tick(4);
      check_bits("int samples", 8'h00, n_int[7:0]);
      summarize();
   end
endmodule
